/* hw/psl_map.svh */
// Offsets-free constant map for the phase status indicator block.
// Assumes a 100 MHz system clock; times are in milliseconds unless noted.
`ifndef PSL_MAP_SVH
`define PSL_MAP_SVH
`define PSL_CLK_PERIOD_NS 32'd10
`define PSL_MS_NS 32'd1000000
`define PSL_STEP_MS 12'h3e8
`define PSL_HOLD_MS 12'hbb8
`define PSL_CYCLE_MS 12'hbb8
`define PSL_BRIEF_MS 12'h064
`define PSL_OV_HALF_MS 12'h064
`define PSL_LOW_HALF_MS 12'h1f4
`define PSL_VOLT_MIN_PCT 8'h14
`define PSL_VOLT_MAX_PCT 8'h7d
`define PSL_FREQ_MIN_HZ 7'h2d
`define PSL_FREQ_MAX_HZ 7'h46
`define PSL_PER_100_MS 12'h0c8
`define PSL_PER_50_MS 12'h116
`define PSL_PER_25_MS 12'h190
`define PSL_PER_10_MS 12'h271
`define PSL_PER_5_MS 12'h38d
`define PSL_PER_1_MS 12'h7d0
`endif

/* hw/psl_pkg.sv */
// Types shared by the phase status indicator block.
// No assumptions beyond a SystemVerilog tool.
package psl_pkg;
   typedef enum logic [1:0] {ST_RED, ST_YEL, ST_GRN, ST_RUN} psl_state_t;
endpackage : psl_pkg

/* hw/psl_flasher.sv */
// One flash generator: square wave whose period is given in milliseconds.
// Assumes a one-cycle millisecond tick from the parent.
`timescale 1ns/100ps
`default_nettype none
module psl_flasher (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ms_tick,
   input wire logic [11:0] period_ms,
   output logic flash_on
);
   logic [11:0] cnt_r;
   logic [11:0] cnt_nxt;
   logic on_r;
   logic on_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (ms_tick) begin
         if (cnt_r >= period_ms - 12'h001) begin
            cnt_nxt = 12'h000;
         end else begin
            cnt_nxt = cnt_r + 12'h001;
         end
      end
      on_nxt = (cnt_nxt < {1'b0, period_ms[11:1]});
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 12'h000;
         on_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         on_r <= on_nxt;
      end
   end

   assign flash_on = on_r;

   // A shorter period may leave the count above it until the next tick wraps it
   a_flash_wrap: assert property (@(posedge clk) disable iff (!rstn)
      (period_ms != 12'h000 && cnt_r < period_ms) |=> cnt_r < $past(period_ms))
      else $error("flash counter ran past its period");
endmodule : psl_flasher
`default_nettype wire

/* hw/psl_status_led.sv */
// Top of the three-phase status indicator block: startup sweep, meter-wide
// patterns and per-phase power flashing on red/green indicators.
// Assumes inputs synchronous to CLK_SYS; yellow is red and green together.
`timescale 1ns/100ps
`default_nettype none
`include "psl_map.svh"
module psl_status_led #(
   parameter int TICK_CYC = `PSL_MS_NS / `PSL_CLK_PERIOD_NS
) (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic [20:0] PWR_PCT,
   input wire logic [2:0] PWR_NEG,
   input wire logic [2:0] PWR_ACTIVE,
   input wire logic [23:0] VOLT_PCT,
   input wire logic [6:0] LINE_FREQ_HZ,
   input wire logic [2:0] CT_POL_INVERT,
   input wire logic LOW_SUPPLY,
   input wire logic FAULT_EVENT,
   input wire logic [7:0] FAULT_CODE,
   output logic [2:0] LED_RED,
   output logic [2:0] LED_GRN,
   output logic [7:0] FAULT_CAUSE
);
   psl_pkg::psl_state_t st_r, st_nxt;
   logic [16:0] pre_r, pre_nxt;
   logic ms_tick;
   logic [11:0] step_r, step_nxt;
   logic [11:0] cyc_r, cyc_nxt;
   logic [11:0] ovc_r, ovc_nxt;
   logic ov_ph_r, ov_ph_nxt;
   logic [11:0] fault_hold_r, fault_hold_nxt;
   logic [11:0] freq_hold_r, freq_hold_nxt;
   logic [7:0] cause_r, cause_nxt;
   logic [2:0] red_r, red_nxt, grn_r, grn_nxt;
   logic [2:0] flash;
   logic [2:0] neg_eff, v_low, v_high;
   logic freq_bad, sel_fault, sel_low, sel_nov, sel_freq;

   // Piecewise linear period between table points, falling with power
   function automatic logic [11:0] rate_period(input logic [6:0] pct);
      int p, t;
      p = int'(pct);
      if (p <= 1) t = int'(`PSL_PER_1_MS);
      else if (p <= 5) t = int'(`PSL_PER_1_MS) -
         (int'(`PSL_PER_1_MS) - int'(`PSL_PER_5_MS)) * (p - 1) / 4;
      else if (p <= 10) t = int'(`PSL_PER_5_MS) -
         (int'(`PSL_PER_5_MS) - int'(`PSL_PER_10_MS)) * (p - 5) / 5;
      else if (p <= 25) t = int'(`PSL_PER_10_MS) -
         (int'(`PSL_PER_10_MS) - int'(`PSL_PER_25_MS)) * (p - 10) / 15;
      else if (p <= 50) t = int'(`PSL_PER_25_MS) -
         (int'(`PSL_PER_25_MS) - int'(`PSL_PER_50_MS)) * (p - 25) / 25;
      else if (p <= 100) t = int'(`PSL_PER_50_MS) -
         (int'(`PSL_PER_50_MS) - int'(`PSL_PER_100_MS)) * (p - 50) / 50;
      else t = int'(`PSL_PER_100_MS);
      return t[11:0];
   endfunction : rate_period

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ph
         psl_flasher u_flash (
            .clk(CLK_SYS),
            .rstn(RSTN),
            .ms_tick(ms_tick),
            .period_ms(rate_period(PWR_PCT[7*g +: 7])),
            .flash_on(flash[g])
         );
         assign neg_eff[g] = PWR_NEG[g] ^ CT_POL_INVERT[g];
         assign v_low[g] = VOLT_PCT[8*g +: 8] < `PSL_VOLT_MIN_PCT;
         assign v_high[g] = VOLT_PCT[8*g +: 8] > `PSL_VOLT_MAX_PCT;
      end
   endgenerate

   assign ms_tick = (pre_r == 17'(TICK_CYC - 1));
   assign freq_bad = (LINE_FREQ_HZ < `PSL_FREQ_MIN_HZ) ||
                     (LINE_FREQ_HZ > `PSL_FREQ_MAX_HZ);
   // Meter-wide pattern priority
   assign sel_fault = FAULT_EVENT || (fault_hold_r != 12'h000);
   assign sel_low = !sel_fault && LOW_SUPPLY;
   assign sel_nov = !sel_fault && !sel_low && (&v_low);
   assign sel_freq = !sel_fault && !sel_low && !sel_nov &&
                     (freq_bad || freq_hold_r != 12'h000);

   always_comb begin
      pre_nxt = ms_tick ? 17'h00000 : pre_r + 17'h00001;
      st_nxt = st_r;
      step_nxt = step_r;
      cyc_nxt = cyc_r;
      ovc_nxt = ovc_r;
      ov_ph_nxt = ov_ph_r;
      fault_hold_nxt = fault_hold_r;
      freq_hold_nxt = freq_hold_r;
      cause_nxt = cause_r;
      red_nxt = 3'h0;
      grn_nxt = 3'h0;
      if (ms_tick) begin
         cyc_nxt = (cyc_r == `PSL_CYCLE_MS - 12'h001) ? 12'h000 : cyc_r + 12'h001;
         if (ovc_r == `PSL_OV_HALF_MS - 12'h001) begin
            ovc_nxt = 12'h000;
            ov_ph_nxt = !ov_ph_r;
         end else begin
            ovc_nxt = ovc_r + 12'h001;
         end
         if (fault_hold_r != 12'h000) fault_hold_nxt = fault_hold_r - 12'h001;
         if (freq_hold_r != 12'h000) freq_hold_nxt = freq_hold_r - 12'h001;
      end
      if (FAULT_EVENT) begin
         fault_hold_nxt = `PSL_HOLD_MS;
         cause_nxt = FAULT_CODE;
      end
      if (freq_bad) freq_hold_nxt = `PSL_HOLD_MS;
      case (st_r)
         psl_pkg::ST_RED, psl_pkg::ST_YEL, psl_pkg::ST_GRN: begin
            red_nxt = (st_r != psl_pkg::ST_GRN) ? 3'h7 : 3'h0;
            grn_nxt = (st_r != psl_pkg::ST_RED) ? 3'h7 : 3'h0;
            if (ms_tick) begin
               if (step_r == `PSL_STEP_MS - 12'h001) begin
                  step_nxt = 12'h000;
                  case (st_r)
                     psl_pkg::ST_RED: st_nxt = psl_pkg::ST_YEL;
                     psl_pkg::ST_YEL: st_nxt = psl_pkg::ST_GRN;
                     default: st_nxt = psl_pkg::ST_RUN;
                  endcase
               end else begin
                  step_nxt = step_r + 12'h001;
               end
            end
         end
         psl_pkg::ST_RUN: begin
            if (sel_fault) begin
               red_nxt = 3'h7;
            end else if (sel_low) begin
               red_nxt = ((cyc_r / `PSL_LOW_HALF_MS) % 12'h002 == 12'h000) ? 3'h7 : 3'h0;
            end else if (sel_nov) begin
               red_nxt = (cyc_r < `PSL_BRIEF_MS) ? 3'h7 : 3'h0;
            end else if (sel_freq) begin
               red_nxt = 3'h7;
               grn_nxt = 3'h7;
            end else begin
               for (int i = 0; i < 3; i++) begin
                  if (v_high[i]) begin
                     red_nxt[i] = ov_ph_r;
                     grn_nxt[i] = !ov_ph_r;
                  end else if (PWR_ACTIVE[i]) begin
                     red_nxt[i] = neg_eff[i] && flash[i];
                     grn_nxt[i] = !neg_eff[i] && flash[i];
                  end else if (!v_low[i]) begin
                     grn_nxt[i] = 1'b1;
                  end
               end
            end
         end
         default: st_nxt = psl_pkg::ST_RED;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         st_r <= psl_pkg::ST_RED;
         pre_r <= 17'h00000;
         step_r <= 12'h000;
         cyc_r <= 12'h000;
         ovc_r <= 12'h000;
         ov_ph_r <= 1'b0;
         fault_hold_r <= 12'h000;
         freq_hold_r <= 12'h000;
         cause_r <= 8'h00;
         red_r <= 3'h0;
         grn_r <= 3'h0;
      end else begin
         st_r <= st_nxt;
         pre_r <= pre_nxt;
         step_r <= step_nxt;
         cyc_r <= cyc_nxt;
         ovc_r <= ovc_nxt;
         ov_ph_r <= ov_ph_nxt;
         fault_hold_r <= fault_hold_nxt;
         freq_hold_r <= freq_hold_nxt;
         cause_r <= cause_nxt;
         red_r <= red_nxt;
         grn_r <= grn_nxt;
      end
   end

   assign LED_RED = red_r;
   assign LED_GRN = grn_r;
   assign FAULT_CAUSE = cause_r;

   logic run0;
   assign run0 = (st_r == psl_pkg::ST_RUN) && !sel_fault && !sel_low && !sel_nov && !sel_freq;

   a_start_red: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      (st_r == psl_pkg::ST_RED) |=> (LED_RED == 3'h7 && LED_GRN == 3'h0))
      else $error("startup red step wrong");
   a_start_order: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      (st_r == psl_pkg::ST_YEL && $past(st_r) != psl_pkg::ST_YEL) |->
      $past(st_r) == psl_pkg::ST_RED && step_r == 12'h000)
      else $error("startup order broken");
   a_start_end: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      (st_r == psl_pkg::ST_GRN && ms_tick && step_r == `PSL_STEP_MS - 12'h001) |=>
      st_r == psl_pkg::ST_RUN)
      else $error("startup did not end after green");
   a_fault_red: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      (FAULT_EVENT && st_r == psl_pkg::ST_RUN) |=> ##1 (LED_RED == 3'h7 && LED_GRN == 3'h0))
      else $error("fault did not light all red");
   a_fault_cause: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      FAULT_EVENT |=> (FAULT_CAUSE == $past(FAULT_CODE) && fault_hold_r == `PSL_HOLD_MS))
      else $error("fault cause or hold not loaded");
   a_freq_yel: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      (st_r == psl_pkg::ST_RUN && sel_freq) |=> (LED_RED == 3'h7 && LED_GRN == 3'h7))
      else $error("bad frequency not yellow");
   a_freq_hold: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      $fell(freq_bad) |-> freq_hold_r == `PSL_HOLD_MS)
      else $error("frequency hold not armed");
   a_neg_red: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      (run0 && !v_high[0] && PWR_ACTIVE[0]) |=>
      (LED_GRN[0] == ($past(!neg_eff[0]) && $past(flash[0])) &&
      LED_RED[0] == ($past(neg_eff[0]) && $past(flash[0]))))
      else $error("power flash colour wrong on phase A");
   a_phase_off: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      (run0 && !v_high[0] && !PWR_ACTIVE[0] && v_low[0]) |=> !LED_RED[0] && !LED_GRN[0])
      else $error("inactive phase A not off");
   a_ov_alt: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      (run0 && v_high[0]) |=> LED_RED[0] != LED_GRN[0])
      else $error("overvoltage not alternating");
   a_low_sync: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      (st_r == psl_pkg::ST_RUN && (sel_low || sel_nov)) |=>
      (LED_RED == 3'h7 || LED_RED == 3'h0) && LED_GRN == 3'h0)
      else $error("unison pattern out of step");

   c_startup: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
      st_r == psl_pkg::ST_GRN ##1 st_r == psl_pkg::ST_RUN);
   c_fault: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
      st_r == psl_pkg::ST_RUN && FAULT_EVENT);
   c_freq: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
      sel_freq && !freq_bad);
   c_nov: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
      st_r == psl_pkg::ST_RUN && sel_nov && cyc_r == 12'h000);
endmodule : psl_status_led
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the phase status indicator block.
// Assumes sweep, hold and flash timing scale with TICK_CYC (1 ms = TK cycles).
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int TK = 2;
   localparam int PT [7] = '{100, 75, 50, 25, 10, 5, 1};
   localparam int LO [7] = '{9, 6, 6, 4, 2, 1, 0};
   localparam int HI [7] = '{11, 11, 8, 6, 4, 3, 2};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [20:0] pct = 21'h0;
   logic [2:0] neg = 3'h0;
   logic [2:0] act = 3'h0;
   logic [23:0] volt = 24'h646464;
   logic [6:0] freq = 7'h32;
   logic [2:0] inv = 3'h0;
   logic low = 1'b0;
   logic flt = 1'b0;
   logic [7:0] code = 8'h00;
   logic [2:0] red;
   logic [2:0] grn;
   logic [7:0] cause;
   int miscompares = 0;
   int comparisons = 0;
   int n_all, n_part, n_rise, n_tot;
   int on_r [3];
   int on_g [3];
   always #5 clk = ~clk;
   psl_status_led #(.TICK_CYC(TK)) i_psl_status_led (
      .CLK_SYS(clk), .RSTN(rstn), .PWR_PCT(pct), .PWR_NEG(neg), .PWR_ACTIVE(act),
      .VOLT_PCT(volt), .LINE_FREQ_HZ(freq), .CT_POL_INVERT(inv), .LOW_SUPPLY(low),
      .FAULT_EVENT(flt), .FAULT_CODE(code), .LED_RED(red), .LED_GRN(grn),
      .FAULT_CAUSE(cause));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rng(input int x, input int lo, input int hi);
      check(32'(x >= lo && x <= hi), 32'h1);
   endtask : rng
   task automatic wait_ms(input int ms);
      repeat (ms * TK) @(negedge clk);
   endtask : wait_ms
   // Counts indicator activity over a window
   task automatic watch(input int ms);
      logic p;
      n_all = 0;
      n_part = 0;
      n_rise = 0;
      n_tot = ms * TK;
      on_r = '{0, 0, 0};
      on_g = '{0, 0, 0};
      p = grn[0];
      repeat (n_tot) begin
         @(negedge clk);
         n_all += (red === 3'h7);
         n_part += (red !== 3'h7 && red !== 3'h0);
         n_rise += (grn[0] === 1'b1 && p === 1'b0);
         p = grn[0];
         for (int i = 0; i < 3; i++) begin
            on_r[i] += (red[i] === 1'b1);
            on_g[i] += (grn[i] === 1'b1);
         end
      end
   endtask : watch
   task automatic t_sweep();
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      wait_ms(500);
      check(red, 3'h7);
      check(grn, 3'h0);
      wait_ms(1000);
      check({red, grn}, 6'h3f);
      wait_ms(1000);
      check({red, grn}, 6'h07);
      wait_ms(1000);
      watch(500);
      check(on_g[0] + on_g[1] + on_g[2], 3 * n_tot);
      check(n_all + n_part, 0);
      $display("test sweep done");
   endtask : t_sweep
   task automatic t_rate();
      act = 3'h1;
      for (int k = 0; k < 7; k++) begin
         pct = {14'h0, 7'(PT[k])};
         wait_ms(100);
         watch(2000);
         rng(n_rise, LO[k], HI[k]);
         check(on_r[0], 0);
      end
      $display("test rate done");
   endtask : t_rate
   task automatic t_sign();
      pct = {7'h32, 7'h32, 7'h32};
      act = 3'h7;
      neg = 3'b110;
      inv = 3'b100;
      wait_ms(1);
      watch(1000);
      rng(on_g[0], 1, n_tot - 1);
      rng(on_r[1], 1, n_tot - 1);
      check(on_g[1], 0);
      rng(on_g[2], 1, n_tot - 1);
      check(on_r[0] + on_r[2], 0);
      act = 3'h0;
      volt = 24'h0a6464;
      wait_ms(1);
      check({red, grn}, 6'h03);
      volt = 24'h646482;
      wait_ms(1);
      watch(1000);
      check(on_r[0] + on_g[0], n_tot);
      rng(on_r[0], 1, n_tot - 1);
      check(on_g[1] - on_r[1], n_tot);
      volt = 24'h646464;
      $display("test sign done");
   endtask : t_sign
   task automatic t_freq();
      freq = 7'h28;
      wait_ms(5);
      watch(500);
      check(n_all, n_tot);
      check(on_g[0] + on_g[1] + on_g[2], 3 * n_tot);
      freq = 7'h32;
      wait_ms(2800);
      check({red, grn}, 6'h3f);
      wait_ms(400);
      check({red, grn}, 6'h07);
      freq = 7'h4b;
      wait_ms(5);
      check({red, grn}, 6'h3f);
      freq = 7'h32;
      wait_ms(3100);
      $display("test freq done");
   endtask : t_freq
   task automatic t_wide();
      volt = 24'h0a0a0a;
      wait_ms(1);
      watch(3000);
      rng(n_all, 190, 210);
      check(n_part + on_g[0] + on_g[1] + on_g[2], 0);
      volt = 24'h646464;
      low = 1'b1;
      wait_ms(1);
      watch(3000);
      rng(n_all, 2900, 3100);
      check(n_part + on_g[0], 0);
      low = 1'b0;
      $display("test wide done");
   endtask : t_wide
   task automatic t_fault();
      flt = 1'b1;
      code = 8'h5a;
      freq = 7'h28;
      @(negedge clk);
      flt = 1'b0;
      freq = 7'h32;
      @(negedge clk);
      check(cause, 8'h5a);
      @(negedge clk);
      check({red, grn}, 6'h38);
      wait_ms(2900);
      check({red, grn}, 6'h38);
      wait_ms(500);
      check({red, grn}, 6'h07);
      flt = 1'b1;
      code = 8'ha5;
      @(negedge clk);
      flt = 1'b0;
      @(negedge clk);
      check(cause, 8'ha5);
      $display("test fault done");
   endtask : t_fault
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #(1000000);
      miscompares++;
      end_of_test();
   end
   initial begin
      t_sweep();
      t_rate();
      t_sign();
      t_freq();
      t_wide();
      t_fault();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
